// file: gam_board.sv
`timescale 1ns/10ps
module gam_board (
  input wire logic [5:0] gpio_out, // Device pin values
  input wire logic [5:0] gpio_oe, // Device pin enables
  input wire logic [5:0] brd_val, // Board drive values
  input wire logic [5:0] brd_oe, // Board drive enables
  output logic [5:0] gpio_in // Resolved pin levels
);
  // Wired-and with pull-ups, so a released low-active line reads idle
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      gpio_in[i] = 1'b1;
      if (gpio_oe[i] && !gpio_out[i]) gpio_in[i] = 1'b0;
      if (brd_oe[i] && !brd_val[i]) gpio_in[i] = 1'b0;
    end
  end
endmodule : gam_board

// file: gam_gpio_mux.sv
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module gam_gpio_mux
  import gam_pkg::*;
(
  input wire logic ref_clk, // 200 MHz system clock
  input wire logic nrst, // Fundamental reset, async, active low
  input wire logic hsel, // AHB slave select
  input wire logic [7:0] haddr, // AHB byte address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  input wire logic cfg_load_valid, // Config loader strobe (SMBus/EEPROM)
  input wire logic [11:0] cfg_load_func, // Config loader function select
  input wire logic [5:0] gpio_in, // Pin levels
  output logic [5:0] gpio_out, // Pin output values
  output logic [5:0] gpio_oe, // Pin output enables
  input wire logic [3:0] part_reset_drive_n, // Internal partition reset, drive line low
  output logic [3:0] partition_reset_n, // Partition reset requests from pins
  output logic failover_event, // One-cycle failover pulse
  input wire logic hotplug_event, // Hot-plug event from hot-plug logic
  input wire logic [2:0] link_up, // Link up, ports 0,4,16 in bits 0,1,2
  input wire logic [2:0] link_active, // Link active, ports 0,4,16
  output logic irq // Level interrupt
);
  logic [11:0] func_q;
  logic [5:0] dir_q;
  logic [5:0] out_q;
  logic fo_en_q;
  logic [4:0] stat_q;
  logic [4:0] mask_q;
  logic [5:0] pin_sync;
  logic [5:0] alt1_out;
  logic [5:0] alt1_oe;
  logic [5:0] alt2_out;
  logic [3:0] preset_d;
  logic [4:0] ev_set;
  logic fo_prev_q;
  logic fo_armed_q;
  logic fo_evt_d;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  logic addr_ph;
  logic rd_clear;

  // Alternate values; hot-plug and link signals are active high, pins low
  assign alt1_out = {~hotplug_event, 1'b0, 4'h0};
  assign alt1_oe = {1'b1, 1'b0, ~part_reset_drive_n};
  assign alt2_out = {~link_active[0], ~link_up[0], ~link_active[1],
                     ~link_up[1], ~link_active[2], ~link_up[2]};

  // One cell per pin
  genvar gi;
  generate
    for (gi = 0; gi < GAM_NPINS; gi++) begin : g_pin
      gam_pin_cell u_cell (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pin_in(gpio_in[gi]),
        .func(func_q[2*gi+:2]),
        .gp_dir(dir_q[gi]),
        .gp_out(out_q[gi]),
        .alt1_out(alt1_out[gi]),
        .alt1_oe(alt1_oe[gi]),
        .alt2_out(alt2_out[gi]),
        .pin_sync(pin_sync[gi]),
        .pin_out_q(gpio_out[gi]),
        .pin_oe_q(gpio_oe[gi])
      );
    end
  endgenerate

  // Partition reset seen on the line, ours or the board's
  always_comb begin
    for (int i = 0; i < GAM_NPART; i++) begin
      preset_d[i] = !((func_q[2*i+:2] == GAM_FN_ALT1) && !pin_sync[i]);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      partition_reset_n <= 4'hf;
    end else begin
      partition_reset_n <= preset_d;
    end
  end

  // Failover edge detect; arm flag avoids a false edge after reset
  assign fo_evt_d = fo_armed_q && fo_en_q && (func_q[2*GAM_FO_PIN+:2] == GAM_FN_ALT1)
                    && (pin_sync[GAM_FO_PIN] != fo_prev_q);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fo_prev_q <= 1'b0;
      fo_armed_q <= 1'b0;
      failover_event <= 1'b0;
    end else begin
      fo_prev_q <= pin_sync[GAM_FO_PIN];
      fo_armed_q <= 1'b1;
      failover_event <= fo_evt_d;
    end
  end

  // AHB address phase capture
  assign addr_ph = hsel && htrans[1] && hready;
  assign rd_clear = rd_pend_q && (addr_q == GAM_OFS_STAT);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_ph && hwrite;
      rd_pend_q <= addr_ph && !hwrite;
      hreadyout <= !(addr_ph && !hwrite); // Reads take one wait state
      hresp <= 1'b0;
      if (addr_ph) begin
        addr_q <= haddr;
      end
      // Read data taken after any preceding write has landed
      if (rd_pend_q) begin
        case (addr_q)
          GAM_OFS_FUNC: hrdata <= {20'h00000, func_q};
          GAM_OFS_DIR: hrdata <= {26'h0000000, dir_q};
          GAM_OFS_OUT: hrdata <= {26'h0000000, out_q};
          GAM_OFS_IN: hrdata <= {26'h0000000, pin_sync};
          GAM_OFS_FOEN: hrdata <= {31'h00000000, fo_en_q};
          GAM_OFS_STAT: hrdata <= {27'h0000000, stat_q};
          GAM_OFS_MASK: hrdata <= {27'h0000000, mask_q};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Function select; config loader wins over a same-cycle bus write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      func_q <= GAM_RST_FUNC;
    end else if (cfg_load_valid) begin
      func_q <= cfg_load_func;
    end else if (wr_pend_q && addr_q == GAM_OFS_FUNC) begin
      func_q <= hwdata[11:0];
    end
  end

  // Plain GPIO and control registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dir_q <= GAM_RST_DIR;
      out_q <= GAM_RST_OUT;
      fo_en_q <= 1'b0;
      mask_q <= GAM_RST_MASK;
    end else if (wr_pend_q) begin
      if (addr_q == GAM_OFS_DIR) dir_q <= hwdata[5:0];
      if (addr_q == GAM_OFS_OUT) out_q <= hwdata[5:0];
      if (addr_q == GAM_OFS_FOEN) fo_en_q <= hwdata[0];
      if (addr_q == GAM_OFS_MASK) mask_q <= hwdata[4:0];
    end
  end

  // Sticky status; a new event beats the read clear
  assign ev_set = {fo_evt_d, partition_reset_n & ~preset_d};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stat_q <= 5'h00;
    end else begin
      stat_q <= (rd_clear ? 5'h00 : stat_q) | ev_set;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & mask_q);
    end
  end

  // Helper for post-reset check
  logic seen_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) seen_q <= 1'b0;
    else seen_q <= 1'b1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  AST_ALT2_LINKUP: assert property ((func_q[1:0] == GAM_FN_ALT2) |=>
    gpio_oe[0] && gpio_out[0] == !$past(link_up[2])) else $error("pin0 link-up wrong");
  AST_ALT2_ACTIVE: assert property ((func_q[3:2] == GAM_FN_ALT2) |=>
    gpio_oe[1] && gpio_out[1] == !$past(link_active[2])) else $error("pin1 link-active wrong");
  AST_GPIO_PLAIN: assert property ((func_q[5:4] == GAM_FN_GPIO) |=>
    gpio_oe[2] == $past(dir_q[2]) && gpio_out[2] == $past(out_q[2])) else $error("plain gpio wrong");
  AST_PRESET_IN: assert property (((func_q[3:2] == GAM_FN_ALT1) && !gpio_in[1])[*4]
    |-> !partition_reset_n[1]) else $error("partition reset missed");
  AST_PRESET_DRV: assert property ((func_q[5:4] == GAM_FN_ALT1) && !part_reset_drive_n[2]
    |=> gpio_oe[2] && !gpio_out[2]) else $error("partition reset not driven");
  AST_FO_EN: assert property (failover_event |-> $past(fo_en_q) &&
    $past(func_q[9:8]) == GAM_FN_ALT1) else $error("failover without enable");
  AST_HOTPLUG: assert property ((func_q[11:10] == GAM_FN_ALT1) |=>
    gpio_oe[5] && gpio_out[5] == !$past(hotplug_event)) else $error("hot-plug pin wrong");
  AST_CFG_LOAD: assert property (cfg_load_valid |=> func_q == $past(cfg_load_func))
    else $error("config load lost");
  AST_RST_IN: assert property (!seen_q |-> gpio_oe == 6'h00 && func_q == GAM_RST_FUNC)
    else $error("pins driven after reset");
  AST_IRQ: assert property (##1 irq == |($past(stat_q) & $past(mask_q)))
    else $error("irq mismatch");
  AST_STICKY: assert property (fo_evt_d |=> stat_q[GAM_ST_FO])
    else $error("failover status lost");

  COV_FO: cover property (failover_event);
  COV_PRESET: cover property ($fell(partition_reset_n[2]));
  COV_STAT_RD: cover property (rd_clear && stat_q != 5'h00);
  COV_IRQ: cover property ($rose(irq));
endmodule : gam_gpio_mux

// file: gam_gpio_mux_tb_top.sv
`timescale 1ns/10ps
module gam_gpio_mux_tb_top;
  import gam_pkg::*;
  logic ref_clk, nrst, hsel, hwrite, hreadyout, hresp, cfg_load_valid, failover_event, hotplug_event, irq;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rd;
  logic [11:0] cfg_load_func;
  logic [5:0] gpio_in, gpio_out, gpio_oe, brd_oe;
  logic [3:0] part_reset_drive_n, partition_reset_n;
  logic [2:0] link_up, link_active;
  int err_count, check_count, cyc, fo_cnt, fo_base;
  gam_gpio_mux gam_gpio_mux_inst (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .cfg_load_valid(cfg_load_valid), .cfg_load_func(cfg_load_func), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .part_reset_drive_n(part_reset_drive_n),
    .partition_reset_n(partition_reset_n), .failover_event(failover_event), .hotplug_event(hotplug_event),
    .link_up(link_up), .link_active(link_active), .irq(irq));
  gam_board gam_board_inst (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .brd_val(6'h00), .brd_oe(brd_oe),
    .gpio_in(gpio_in));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Pulse counter; a level held high would count every cycle
  always @(posedge ref_clk) begin
    cyc++;
    if (failover_event === 1'b1) fo_cnt++;
    if (cyc == 5000) begin
      err_count++;
      stop_test();
    end
  end
  task stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Returns on an edge: reads see the settled values of the cycle before, drives land on the edge
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  // Single AHB transfer, waits on hready in both phases
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task t_reset();
    chk(32'(gpio_oe), 32'h0);
    ahb(1'b0, GAM_OFS_FUNC, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, GAM_OFS_DIR, 32'h0);
    chk(rd, 32'h0);
    chk(32'(hresp), 32'h0);
  endtask : t_reset
  task t_plain();
    brd_oe <= 6'h05;
    ahb(1'b1, GAM_OFS_DIR, 32'h30);
    ahb(1'b1, GAM_OFS_OUT, 32'h10);
    tick(4);
    chk(32'(gpio_oe), 32'h30);
    chk(32'(gpio_out), 32'h10);
    ahb(1'b0, GAM_OFS_IN, 32'h0);
    chk(rd, 32'h1a);
    chk(32'(partition_reset_n), 32'hf);
    brd_oe <= 6'h00;
    ahb(1'b1, GAM_OFS_DIR, 32'h0);
  endtask : t_plain
  task t_part();
    ahb(1'b1, GAM_OFS_MASK, 32'h02);
    ahb(1'b1, GAM_OFS_FUNC, 32'h055);
    part_reset_drive_n <= 4'hb;
    tick(5);
    chk(32'(gpio_oe), 32'h04);
    chk(32'(irq), 32'h0);
    brd_oe <= 6'h02;
    tick(5);
    chk(32'(partition_reset_n), 32'h9);
    chk(32'(irq), 32'h1);
    ahb(1'b0, GAM_OFS_STAT, 32'h0);
    chk(rd, 32'h06);
    tick(2);
    chk(32'(irq), 32'h0);
    brd_oe <= 6'h00;
    part_reset_drive_n <= 4'hf;
  endtask : t_part
  task t_fail();
    brd_oe <= 6'h10;
    ahb(1'b1, GAM_OFS_FUNC, 32'h100);
    ahb(1'b1, GAM_OFS_FOEN, 32'h1);
    ahb(1'b0, GAM_OFS_STAT, 32'h0);
    tick(5);
    fo_base = fo_cnt;
    brd_oe <= 6'h00;
    tick(5);
    brd_oe <= 6'h10;
    tick(5);
    chk(32'(fo_cnt - fo_base), 32'h2);
    chk(32'(gpio_oe), 32'h0);
    ahb(1'b0, GAM_OFS_STAT, 32'h0);
    chk(rd, 32'h10);
    ahb(1'b1, GAM_OFS_FOEN, 32'h0);
    brd_oe <= 6'h00;
    tick(5);
    chk(32'(fo_cnt - fo_base), 32'h2);
  endtask : t_fail
  task t_hot();
    ahb(1'b1, GAM_OFS_FUNC, 32'h400);
    hotplug_event <= 1'b1;
    tick(4);
    chk(32'({gpio_oe[5], gpio_out[5]}), 32'h2);
    hotplug_event <= 1'b0;
    tick(4);
    chk(32'({gpio_oe[5], gpio_out[5]}), 32'h3);
  endtask : t_hot
  task t_alt2();
    link_up <= 3'b101;
    link_active <= 3'b010;
    cfg_load_valid <= 1'b1;
    @(posedge ref_clk);
    cfg_load_valid <= 1'b0;
    tick(4);
    chk(32'(gpio_oe), 32'h3f);
    chk(32'(gpio_out), 32'h26);
    ahb(1'b0, GAM_OFS_FUNC, 32'h0);
    chk(rd, 32'haaa);
    ahb(1'b1, GAM_OFS_FUNC, 32'hfff);
    tick(4);
    chk(32'(gpio_oe), 32'h0);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
  endtask : t_alt2
  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 8'h00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    cfg_load_valid = 1'b0;
    cfg_load_func = 12'haaa;
    hotplug_event = 1'b0;
    link_up = 3'b000;
    link_active = 3'b000;
    part_reset_drive_n = 4'hf;
    brd_oe = 6'h00;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_plain();
    t_part();
    t_fail();
    t_hot();
    t_alt2();
    stop_test();
  end
endmodule : gam_gpio_mux_tb_top

// file: gam_pin_cell.sv
`timescale 1ns/10ps
module gam_pin_cell
  import gam_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic pin_in, // Raw pin level
  input wire logic [1:0] func, // Selected function
  input wire logic gp_dir, // Plain mode direction, 1 drives
  input wire logic gp_out, // Plain mode output value
  input wire logic alt1_out, // First alternate value
  input wire logic alt1_oe, // First alternate enable
  input wire logic alt2_out, // Second alternate value
  output logic pin_sync, // Synchronised pin level
  output logic pin_out_q, // Pin output value
  output logic pin_oe_q // Pin output enable
);
  logic s1_q;

  // Two-flop synchroniser, first stage read only by second
  // Resets to the pulled-up idle level, so an early alt select sees no false low
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      s1_q <= pin_in;
      pin_sync <= s1_q;
    end
  end

  // Output mux, registered so pins never glitch on select changes
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      case (func)
        GAM_FN_GPIO: begin
          pin_out_q <= gp_out;
          pin_oe_q <= gp_dir;
        end
        GAM_FN_ALT1: begin
          pin_out_q <= alt1_out;
          pin_oe_q <= alt1_oe;
        end
        GAM_FN_ALT2: begin
          pin_out_q <= alt2_out;
          pin_oe_q <= 1'b1;
        end
        default: begin
          // Reserved code parks the pin as an input
          pin_out_q <= 1'b0;
          pin_oe_q <= 1'b0;
        end
      endcase
    end
  end
endmodule : gam_pin_cell

// file: gam_pkg.sv
package gam_pkg;
  localparam int GAM_NPINS = 6;
  localparam int GAM_NPART = 4;
  localparam int GAM_FO_PIN = 4;
  localparam int GAM_HP_PIN = 5;
  // Pin function codes, two bits per pin
  typedef enum logic [1:0] {
    GAM_FN_GPIO = 2'b00,
    GAM_FN_ALT1 = 2'b01,
    GAM_FN_ALT2 = 2'b10,
    GAM_FN_RSVD = 2'b11
  } gam_func_t;
  // Register byte offsets
  localparam logic [7:0] GAM_OFS_FUNC = 8'h00;
  localparam logic [7:0] GAM_OFS_DIR = 8'h04;
  localparam logic [7:0] GAM_OFS_OUT = 8'h08;
  localparam logic [7:0] GAM_OFS_IN = 8'h0c;
  localparam logic [7:0] GAM_OFS_FOEN = 8'h10;
  localparam logic [7:0] GAM_OFS_STAT = 8'h14;
  localparam logic [7:0] GAM_OFS_MASK = 8'h18;
  // Reset values
  localparam logic [11:0] GAM_RST_FUNC = 12'h000;
  localparam logic [5:0] GAM_RST_DIR = 6'h00;
  localparam logic [5:0] GAM_RST_OUT = 6'h00;
  localparam logic [4:0] GAM_RST_MASK = 5'h00;
  // Status bit positions: partition resets in 3:0, failover in 4
  localparam int GAM_ST_FO = 4;
endpackage : gam_pkg
